// ==== pwmost_top.sv ====
// top: wishbone registers, sync source select, trigger compare, output control
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Sync source code 000 picks the external input, 011 trigger output a, 010 trigger output b.
// - The postscaler sends a special event only on every (n+1)th compare match, 1111 is 1:16.
// - Swap set routes the high output to the low pin and the low output to the high pin.
// - Override sync set applies override data on the timebase; clear applies next clock.
// - With the lock configuration set, output control writes need the unlock sequence first.
// - A 16-bit read/write trigger compare value resets to zero.
module pwmost_top import pwmost_pkg::*; #(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned PS_W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [PWMOST_AW-1:0] wb_adr_i,
  input wire logic [PWMOST_DW-1:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [PWMOST_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic io_control_lock_i,
  input wire logic external_sync_input_i,
  input wire logic trigger_gen_output_a_i,
  input wire logic trigger_gen_output_b_i,
  input wire logic [CNT_W-1:0] local_count_i,
  input wire logic local_timebase_i,
  input wire logic period_match_i,
  input wire logic special_match_i,
  input wire logic gen_high_i,
  input wire logic gen_low_i,
  output logic high_side_output_o,
  output logic low_side_output_o,
  output logic sync_o,
  output logic special_event_o,
  output logic adc_trigger_o
);
  logic [15:0] tb_ctl_q;
  logic [15:0] io_ctl_q;
  logic [CNT_W-1:0] trig_cmp_q;
  logic unlock_arm_q, unlocked_q;
  logic [PWMOST_DW-1:0] rd_d;
  pwmost_pair_t pins_w;

  // bus decode
  wire req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_w = req_w && wb_we_i;
  wire lo_w = wb_sel_i[0];
  wire hi_w = wb_sel_i[1];
  wire hit_tb_w = (wb_adr_i == PWMOST_OFF_TBCTL);
  wire hit_io_w = (wb_adr_i == PWMOST_OFF_IOCTL);
  wire hit_trig_w = (wb_adr_i == PWMOST_OFF_TRIG);
  wire hit_key_w = (wb_adr_i == PWMOST_OFF_UNLOCK);
  wire hit_st_w = (wb_adr_i == PWMOST_OFF_STATUS);
  wire full16_w = lo_w && hi_w;
  // locked writes to io control are dropped unless unlocked
  wire io_open_w = !io_control_lock_i || unlocked_q;
  wire io_wr_w = wr_w && hit_io_w && io_open_w;
  wire key_wr_w = wr_w && hit_key_w && full16_w;
  wire key1_w = key_wr_w && (wb_dat_i[15:0] == PWMOST_KEY1);
  wire key2_w = key_wr_w && (wb_dat_i[15:0] == PWMOST_KEY2);

  wire tb_en_w = tb_ctl_q[PWMOST_TB_EN_BIT];
  wire [2:0] sync_sel_w = tb_ctl_q[PWMOST_TB_SYNC_LSB +: 3];
  wire [PS_W-1:0] ps_w = tb_ctl_q[PWMOST_TB_PS_LSB +: PS_W];
  logic sync_d;

  // reserved codes select nothing
  always_comb begin
    unique case (sync_sel_w)
      PWMOST_SRC_EXT: sync_d = external_sync_input_i;
      PWMOST_SRC_TGA: sync_d = trigger_gen_output_a_i;
      PWMOST_SRC_TGB: sync_d = trigger_gen_output_b_i;
      default: sync_d = 1'b0;
    endcase
  end

  wire adc_d = local_timebase_i && (local_count_i == trig_cmp_q);

  assign rd_d = hit_tb_w ? {16'h0000, tb_ctl_q} :
                hit_io_w ? {16'h0000, io_ctl_q} :
                hit_trig_w ? {{(PWMOST_DW-CNT_W){1'b0}}, trig_cmp_q} :
                hit_st_w ? {30'h00000000, io_control_lock_i, unlocked_q} :
                PWMOST_UNMAPPED;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req_w;
      wb_dat_o <= (req_w && !wb_we_i) ? rd_d : '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tb_ctl_q <= PWMOST_TB_RESET;
    end else if (wr_w && hit_tb_w) begin
      if (lo_w) tb_ctl_q[7:0] <= wb_dat_i[7:0];
      if (hi_w) tb_ctl_q[15:8] <= wb_dat_i[15:8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_ctl_q <= PWMOST_IO_RESET;
    end else if (io_wr_w) begin
      if (lo_w) io_ctl_q[7:0] <= wb_dat_i[7:0];
      if (hi_w) io_ctl_q[15:8] <= wb_dat_i[15:8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_cmp_q <= PWMOST_TRIG_RESET[CNT_W-1:0];
    end else if (wr_w && hit_trig_w) begin
      if (lo_w) trig_cmp_q[7:0] <= wb_dat_i[7:0];
      if (hi_w) trig_cmp_q[CNT_W-1:8] <= wb_dat_i[CNT_W-1:8];
    end
  end

  // unlock: key1 then key2 on back-to-back key writes; one io write consumes it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unlock_arm_q <= 1'b0;
      unlocked_q <= 1'b0;
    end else begin
      if (key_wr_w) begin
        unlock_arm_q <= key1_w;
      end
      if (key2_w && unlock_arm_q) begin
        unlocked_q <= 1'b1;
      end else if (wr_w && hit_io_w) begin
        unlocked_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_o <= 1'b0;
      adc_trigger_o <= 1'b0;
    end else begin
      sync_o <= tb_en_w && sync_d;
      adc_trigger_o <= adc_d;
    end
  end

  pwmost_postscale #(
    .PS_W(PS_W)
  ) u_ps (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(tb_en_w),
    .match_i(special_match_i),
    .ratio_i(ps_w),
    .event_o(special_event_o)
  );

  pwmost_out_map u_map (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .gen_i(pwmost_pair_t'{high: gen_high_i, low: gen_low_i}),
    .ovr_en_i(pwmost_pair_t'{high: io_ctl_q[PWMOST_IO_OVEN_H_BIT],
      low: io_ctl_q[PWMOST_IO_OVEN_L_BIT]}),
    .ovr_dat_i(pwmost_pair_t'{high: io_ctl_q[PWMOST_IO_OVDAT_LSB+1],
      low: io_ctl_q[PWMOST_IO_OVDAT_LSB]}),
    .override_sync_select_i(io_ctl_q[PWMOST_IO_OVERRIDE_SYNC_SELECT_BIT]),
    .tb_boundary_i(period_match_i),
    .swap_i(io_ctl_q[PWMOST_IO_SWAP_BIT]),
    .pin_o(pins_w)
  );

  assign high_side_output_o = pins_w.high;
  assign low_side_output_o = pins_w.low;

  adc_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    adc_trigger_o |=> !adc_trigger_o || ($past(local_count_i) == trig_cmp_q))
    else $error("adc trigger held without a new match");
  adc_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    adc_d |=> adc_trigger_o)
    else $error("adc trigger missed a compare match");
  lock_guard_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_w && hit_io_w && io_control_lock_i && !unlocked_q |=> $stable(io_ctl_q))
    else $error("locked io control accepted a write");
  trig_reset_a: assert property (@(posedge clk_i)
    rst_i |=> trig_cmp_q == '0)
    else $error("trigger compare not cleared by reset");
  sync_ext_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tb_en_w && sync_sel_w == PWMOST_SRC_EXT |=> sync_o == $past(external_sync_input_i))
    else $error("external sync not routed");
  sync_res_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sync_sel_w == 3'h1 |=> !sync_o)
    else $error("reserved sync code produced a sync");
  bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req_w |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle after request");
endmodule
`default_nettype wire

// ==== pwmost_pkg.sv ====
// package: register map, field layouts and encodings for the pwm sync/trigger block
package pwmost_pkg;
  localparam int unsigned PWMOST_AW = 6;
  localparam int unsigned PWMOST_DW = 32;
  // byte offsets on the register bus
  localparam logic [5:0] PWMOST_OFF_TBCTL = 6'h00;
  localparam logic [5:0] PWMOST_OFF_IOCTL = 6'h04;
  localparam logic [5:0] PWMOST_OFF_TRIG = 6'h08;
  localparam logic [5:0] PWMOST_OFF_UNLOCK = 6'h0c;
  localparam logic [5:0] PWMOST_OFF_STATUS = 6'h10;
  // timebase control fields
  localparam int unsigned PWMOST_TB_EN_BIT = 15;
  localparam int unsigned PWMOST_TB_SYNC_LSB = 4;
  localparam int unsigned PWMOST_TB_PS_LSB = 0;
  // io control fields
  localparam int unsigned PWMOST_IO_OVEN_H_BIT = 9;
  localparam int unsigned PWMOST_IO_OVEN_L_BIT = 8;
  localparam int unsigned PWMOST_IO_OVDAT_LSB = 6;
  localparam int unsigned PWMOST_IO_SWAP_BIT = 1;
  localparam int unsigned PWMOST_IO_OVERRIDE_SYNC_SELECT_BIT = 0;
  localparam logic [15:0] PWMOST_IO_RESET = 16'h0000;
  localparam logic [15:0] PWMOST_TRIG_RESET = 16'h0000;
  localparam logic [15:0] PWMOST_TB_RESET = 16'h0000;
  // two-word unlock sequence
  localparam logic [15:0] PWMOST_KEY1 = 16'habcd;
  localparam logic [15:0] PWMOST_KEY2 = 16'h4321;
  localparam logic [31:0] PWMOST_UNMAPPED = 32'h00000000;
  typedef enum logic [2:0] {
    PWMOST_SRC_EXT = 3'h0,
    PWMOST_SRC_TGB = 3'h2,
    PWMOST_SRC_TGA = 3'h3
  } pwmost_sync_src_t;
  typedef struct packed {
    logic high;
    logic low;
  } pwmost_pair_t;
  typedef struct packed {
    logic [PWMOST_AW-1:0] adr;
    logic [PWMOST_DW-1:0] dat;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } pwmost_wb_req_t;
endpackage

// ==== pwmost_postscale.sv ====
// special event postscaler: one output per (n+1) compare matches
`timescale 1ns/1ps
`default_nettype none
module pwmost_postscale import pwmost_pkg::*; #(
  parameter int unsigned PS_W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic match_i,
  input wire logic [PS_W-1:0] ratio_i,
  output logic event_o
);
  logic [PS_W-1:0] cnt_q;
  wire last_w = (cnt_q == ratio_i);
  wire fire_w = enable_i && match_i && last_w;

  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_i) begin
      cnt_q <= '0;
      event_o <= 1'b0;
    end else begin
      event_o <= fire_w;
      if (match_i) begin
        cnt_q <= last_w ? '0 : cnt_q + 1'b1;
      end
    end
  end

  postscale_period_a: assert property (@(posedge clk_i) disable iff (rst_i)
    event_o |-> $past(last_w) && $past(match_i))
    else $error("postscale event without terminal match");
endmodule
`default_nettype wire

// ==== pwmost_out_map.sv ====
// output path: override select, override timing and pin swap
`timescale 1ns/1ps
`default_nettype none
module pwmost_out_map import pwmost_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire pwmost_pair_t gen_i,
  input wire pwmost_pair_t ovr_en_i,
  input wire pwmost_pair_t ovr_dat_i,
  input wire logic override_sync_select_i,
  input wire logic tb_boundary_i,
  input wire logic swap_i,
  output pwmost_pair_t pin_o
);
  pwmost_pair_t ovr_en_q, ovr_dat_q;
  pwmost_pair_t sel_w, pin_d;
  // with override_sync_select the override only moves at a timebase boundary
  wire take_w = !override_sync_select_i || tb_boundary_i;

  assign sel_w.high = ovr_en_q.high ? ovr_dat_q.high : gen_i.high;
  assign sel_w.low = ovr_en_q.low ? ovr_dat_q.low : gen_i.low;
  assign pin_d.high = swap_i ? sel_w.low : sel_w.high;
  assign pin_d.low = swap_i ? sel_w.high : sel_w.low;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovr_en_q <= '0;
      ovr_dat_q <= '0;
      pin_o <= '0;
    end else begin
      if (take_w) begin
        ovr_en_q <= ovr_en_i;
        ovr_dat_q <= ovr_dat_i;
      end
      pin_o <= pin_d;
    end
  end

  ovr_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    override_sync_select_i && !tb_boundary_i |=> $stable(ovr_dat_q))
    else $error("override changed off the timebase boundary");
  ovr_async_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !override_sync_select_i |=> ovr_dat_q == $past(ovr_dat_i))
    else $error("override not taken at next clock");
  swap_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    swap_i |=> pin_o.high == $past(sel_w.low))
    else $error("swap did not route low output to high pin");
endmodule
`default_nettype wire

// ==== pwmost_stage_model.sv ====
// far-side model: adc start-of-conversion input counting trigger-high cycles
`timescale 1ns/1ps
`default_nettype none
module pwmost_stage_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic adc_trig_i,
  output var int trig_cnt_o
);
  // counts cycles with the trigger high, so a stretched trigger shows up as an extra conversion
  always @(posedge clk_i) begin
    if (rst_i) begin
      trig_cnt_o <= 0;
    end else if (adc_trig_i === 1'h1) begin
      trig_cnt_o <= trig_cnt_o + 1;
    end
  end
endmodule
`default_nettype wire

// ==== pwm_output_sync_trigger_tb_top.sv ====
// self-checking bench for the pwm sync, trigger and output block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module pwm_output_sync_trigger_tb_top;
  import pwmost_pkg::*;
  pwmost_wb_req_t req = '0;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic [31:0] rd, rdat, v;
  logic [31:0] rnd = 32'hcd9eee09;
  logic [15:0] cnt = 16'h0;
  logic ack, hi, lo, sync, sev, adc;
  logic lock = 1'h0, ext = 1'h0, tga = 1'h0, tgb = 1'h0, ltb = 1'h0;
  logic pm = 1'h0, sm = 1'h0, gh = 1'h0, gl = 1'h0;
  int n_mismatch = 0, n_checks = 0, n_evt = 0, trig_cnt, base;
  pwmost_top pwmost_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(req.adr),
    .wb_dat_i(req.dat), .wb_sel_i(req.sel), .wb_we_i(req.we), .wb_cyc_i(req.cyc),
    .wb_stb_i(req.stb), .wb_dat_o(rd), .wb_ack_o(ack), .io_control_lock_i(lock),
    .external_sync_input_i(ext), .trigger_gen_output_a_i(tga),
    .trigger_gen_output_b_i(tgb), .local_count_i(cnt), .local_timebase_i(ltb),
    .period_match_i(pm), .special_match_i(sm), .gen_high_i(gh), .gen_low_i(gl),
    .high_side_output_o(hi), .low_side_output_o(lo), .sync_o(sync),
    .special_event_o(sev), .adc_trigger_o(adc));
  pwmost_stage_model pwmost_stage_model_i (.clk_i(clk_i), .rst_i(rst_i),
    .adc_trig_i(adc), .trig_cnt_o(trig_cnt));
  initial forever #5 clk_i = ~clk_i;
  always @(negedge clk_i) if (sev === 1'h1) n_evt++;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic exp_sync(input logic [2:0] c, input logic e, a, b);
    return (c == 3'h0) ? e : (c == 3'h3) ? a : (c == 3'h2) ? b : 1'h0;
  endfunction
  function automatic logic [1:0] exp_pins(input logic sw, h, l);
    return sw ? {l, h} : {h, l};
  endfunction
  task automatic wb(input logic [5:0] a, input logic [31:0] d, input logic w);
    @(posedge clk_i);
    req <= '{adr: a, dat: d, sel: 4'h3, we: w, cyc: 1'h1, stb: 1'h1};
    do @(posedge clk_i); while (ack !== 1'h1);
    rdat = rd;
    req <= '0;
  endtask
  task automatic stop_test;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    stop_test;
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(PWMOST_OFF_TRIG, 32'h0, 1'h0);
    `CHK(rdat, 32'h0)
    rnd = lfsr(rnd);
    wb(PWMOST_OFF_TRIG, {16'h0, rnd[15:0]}, 1'h1);
    wb(PWMOST_OFF_TRIG, 32'h0, 1'h0);
    `CHK(rdat, {16'h0, rnd[15:0]})
    wb(6'h14, 32'h0, 1'h0);
    `CHK(rdat, PWMOST_UNMAPPED)
    // a matching count must fire only on the local timebase
    for (int t = 0; t < 2; t++) begin
      base = trig_cnt;
      @(posedge clk_i);
      cnt <= rnd[15:0];
      ltb <= t[0];
      @(posedge clk_i);
      cnt <= rnd[15:0] + 16'h1;
      @(negedge clk_i);
      `CHK(adc, t[0])
      @(negedge clk_i);
      `CHK(adc, 1'h0)
      `CHK(trig_cnt - base, t)
    end
    // sync code sits in bits 6:4; the external source is a level held steady per check
    for (int c = 0; c < 8; c++) begin
      wb(PWMOST_OFF_TBCTL, 32'h0, 1'h1);
      wb(PWMOST_OFF_TBCTL, {25'h0, c[2:0], 4'h0}, 1'h1);
      wb(PWMOST_OFF_TBCTL, {16'h0, 1'h1, 8'h0, c[2:0], 4'h0}, 1'h1);
      rnd = lfsr(rnd);
      @(posedge clk_i);
      {ext, tga, tgb} <= rnd[2:0];
      repeat (2) @(negedge clk_i);
      `CHK(sync, exp_sync(c[2:0], rnd[2], rnd[1], rnd[0]))
    end
    for (int k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      v = (k == 0) ? 32'h0 : (k == 1) ? 32'hf : {28'h0, rnd[3:0]};
      wb(PWMOST_OFF_TBCTL, 32'h0, 1'h1);
      wb(PWMOST_OFF_TBCTL, v, 1'h1);
      wb(PWMOST_OFF_TBCTL, v | 32'h8000, 1'h1);
      n_evt = 0;
      repeat (2 * (v + 1)) begin
        @(posedge clk_i);
        sm <= 1'h1;
        @(posedge clk_i);
        sm <= 1'h0;
      end
      repeat (2) @(posedge clk_i);
      `CHK(n_evt, 2)
    end
    wb(PWMOST_OFF_TBCTL, 32'h0, 1'h1);
    for (int s = 0; s < 4; s++) begin
      rnd = lfsr(rnd);
      wb(PWMOST_OFF_IOCTL, {30'h0, s[0], 1'h0}, 1'h1);
      @(posedge clk_i);
      {gh, gl} <= rnd[1:0];
      repeat (3) @(negedge clk_i);
      `CHK({hi, lo}, exp_pins(s[0], rnd[1], rnd[0]))
    end
    wb(PWMOST_OFF_IOCTL, {22'h0, 2'h3, rnd[1:0], 6'h0}, 1'h1);
    repeat (2) @(negedge clk_i);
    `CHK({hi, lo}, rnd[1:0])
    // synced override must wait for the boundary pulse
    wb(PWMOST_OFF_IOCTL, {22'h0, 2'h3, ~rnd[1:0], 6'h1}, 1'h1);
    repeat (4) @(negedge clk_i);
    `CHK({hi, lo}, rnd[1:0])
    @(posedge clk_i);
    pm <= 1'h1;
    @(posedge clk_i);
    pm <= 1'h0;
    repeat (2) @(negedge clk_i);
    `CHK({hi, lo}, ~rnd[1:0])
    @(posedge clk_i);
    lock <= 1'h1;
    wb(PWMOST_OFF_IOCTL, 32'h0, 1'h1);
    wb(PWMOST_OFF_IOCTL, 32'h0, 1'h0);
    `CHK(rdat[15:0], {6'h0, 2'h3, ~rnd[1:0], 6'h1})
    wb(PWMOST_OFF_UNLOCK, {16'h0, PWMOST_KEY1}, 1'h1);
    wb(PWMOST_OFF_UNLOCK, {16'h0, PWMOST_KEY2}, 1'h1);
    wb(PWMOST_OFF_IOCTL, 32'h2, 1'h1);
    wb(PWMOST_OFF_IOCTL, 32'h0, 1'h0);
    `CHK(rdat, 32'h2)
    // lock input still high, unlock consumed by the io write
    wb(PWMOST_OFF_STATUS, 32'h0, 1'h0);
    `CHK(rdat, 32'h2)
    stop_test;
  end
endmodule
`default_nettype wire
